//--- logic/scp_defs.svh
// Constants for the two-wire client register port
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// Bus addresses and byte length
`define SCP_ARA_ADDR     7'h0C
`define SCP_CLIENT_ADDR  7'h2E
`define SCP_BYTE_BITS    4'h8

// Reset values
`define SCP_PTR_RST      8'h00

// Timing in printed units, and system clock rate
`define SCP_SYS_HZ       10000000
`define SCP_LOW_TO_MS    30
`define SCP_HIGH_TO_US   150
`define SCP_LOW_TO_CYC   ((`SCP_LOW_TO_MS * (`SCP_SYS_HZ / 1000)))
`define SCP_HIGH_TO_CYC  ((`SCP_HIGH_TO_US * `SCP_SYS_HZ + 999999) / 1000000)

`endif

//--- logic/scp_pkg.sv
// Types shared by the two-wire client register port
package scp_pkg;

  // Protocol engine states, one-hot
  typedef enum logic [4:0] {
    scp_idle = 5'h01,
    scp_rxb  = 5'h02,
    scp_ack  = 5'h04,
    scp_txb  = 5'h08,
    scp_mack = 5'h10
  } scp_state_e;

endpackage

//--- logic/scp_port.sv
// Two-wire client port reaching a byte-wide register set via a pointer
`include "scp_defs.svh"

module scp_port
  import scp_pkg::*;
#(
  parameter logic [6:0] CLIENT_ADDR = `SCP_CLIENT_ADDR, // arbitrary value
  parameter int         LOW_TO_CYC  = `SCP_LOW_TO_CYC,
  parameter int         HIGH_TO_CYC = `SCP_HIGH_TO_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       link_clk,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            alert_o,
  output logic            alert_oe,
  input  wire logic       alert_req,
  input  wire logic       alert_mask,
  input  wire logic       alert_irq_mode,
  input  wire logic       timeout_disable_bit,
  output logic            mask_set,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);

  localparam int LW = $clog2(LOW_TO_CYC + 1);
  localparam int HW = $clog2(HIGH_TO_CYC + 1);

  // ****************************************************
  // Link domain: reset and input synchronisers
  // ****************************************************
  logic [1:0]  lrst_sy;
  logic        lrst;
  logic [4:0]  l_m;
  logic [4:0]  l_s;
  logic [4:0]  l_p;
  logic        alert_ara;
  logic        abort_tgl;
  logic        rd_tgl;
  logic [7:0]  rd_hold;

  // Reset from the system domain, two stages
  always_ff @(posedge link_clk) begin
    lrst_sy <= {lrst_sy[0], reset};
  end
  assign lrst = lrst_sy[1];

  // Pins, the alert level and toggles from the system side; third stage only for edges
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      l_m <= 5'h18;
      l_s <= 5'h18;
      l_p <= 5'h18;
    end else begin
      l_m <= {scl_i, sda_i, alert_ara, abort_tgl, rd_tgl};
      l_s <= l_m;
      l_p <= l_s;
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic abort_ev;
  logic rd_ev;

  assign scl       = l_s[4];
  assign sda       = l_s[3];
  assign scl_rise  = scl & ~l_p[4];
  assign scl_fall  = ~scl & l_p[4];
  assign bus_start = scl & l_p[4] & l_p[3] & ~sda;
  assign bus_stop  = scl & l_p[4] & ~l_p[3] & sda;
  assign abort_ev  = l_s[1] ^ l_p[1];
  assign rd_ev     = l_s[0] ^ l_p[0];

  // Read data arrives by toggle; the held word is stable by then
  logic [7:0] rd_data_l;
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      rd_data_l <= 8'h00;
    end else if (rd_ev) begin
      rd_data_l <= rd_hold;
    end
  end

  // ****************************************************
  // Link domain: protocol engine
  // ****************************************************
  scp_state_e  state;
  logic [3:0]  cnt;
  logic [7:0]  sh;
  logic [7:0]  ptr;
  logic        is_addr;
  logic        first;
  logic        rd_dir;
  logic        ara;
  logic        host_ack;
  logic        req_tgl;
  logic        req_wr;
  logic [7:0]  req_addr;
  logic [7:0]  req_data;
  logic        mask_tgl;

  // Data line is open drain: only ever driven low
  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

  // Byte framing, acknowledge and pointer handling
  always_ff @(posedge link_clk) begin
    if (lrst || abort_ev) begin
      state   <= scp_idle;
      sda_oe  <= 1'b0;
      cnt     <= 4'h0;
      is_addr <= 1'b0;
      first   <= 1'b0;
      ara     <= 1'b0;
      if (lrst) begin
        sh       <= 8'h00;
        ptr      <= `SCP_PTR_RST;
        rd_dir   <= 1'b0;
        host_ack <= 1'b0;
        req_tgl  <= 1'b0;
        req_wr   <= 1'b0;
        req_addr <= 8'h00;
        req_data <= 8'h00;
        mask_tgl <= 1'b0;
      end
    end else if (bus_start) begin
      state   <= scp_rxb;
      sda_oe  <= 1'b0;
      cnt     <= 4'h0;
      is_addr <= 1'b1;
      ara     <= 1'b0;
    end else if (bus_stop) begin
      state  <= scp_idle;
      sda_oe <= 1'b0;
      ara    <= 1'b0;
    end else begin
      unique case (state)
        scp_idle: begin
          sda_oe <= 1'b0;
        end
        scp_rxb: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda};
            cnt <= cnt + 4'h1;
          end else if (scl_fall && cnt == `SCP_BYTE_BITS) begin
            if (is_addr) begin
              is_addr <= 1'b0;
              first   <= ~sh[0];
              if (sh[7:1] == CLIENT_ADDR) begin
                sda_oe <= 1'b1;
                state  <= scp_ack;
                rd_dir <= sh[0];
                if (sh[0]) begin
                  // Fetch early so the byte is ready for bit 7
                  req_wr   <= 1'b0;
                  req_addr <= ptr;
                  req_tgl  <= ~req_tgl;
                end
              end else if (sh == {`SCP_ARA_ADDR, 1'b1} && l_s[2]) begin
                sda_oe <= 1'b1;
                state  <= scp_ack;
                rd_dir <= 1'b1;
                ara    <= 1'b1;
              end else begin
                state <= scp_idle;
              end
            end else if (first) begin
              ptr    <= sh;
              first  <= 1'b0;
              sda_oe <= 1'b1;
              state  <= scp_ack;
            end else begin
              // Every further byte is register data, no count byte
              req_wr   <= 1'b1;
              req_addr <= ptr;
              req_data <= sh;
              req_tgl  <= ~req_tgl;
              ptr      <= ptr + 8'h01;
              sda_oe   <= 1'b1;
              state    <= scp_ack;
            end
          end
        end
        scp_ack: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            if (rd_dir) begin
              sh     <= ara ? {CLIENT_ADDR, 1'b0} : rd_data_l;
              sda_oe <= ara ? ~CLIENT_ADDR[6] : ~rd_data_l[7];
              state  <= scp_txb;
            end else begin
              sda_oe <= 1'b0;
              state  <= scp_rxb;
            end
          end
        end
        scp_txb: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
            if (ara && sh[7] && !sda) begin
              // Another device won the bit: give up, mask untouched
              sda_oe <= 1'b0;
              state  <= scp_idle;
            end
          end else if (scl_fall) begin
            if (cnt == `SCP_BYTE_BITS) begin
              sda_oe <= 1'b0;
              state  <= scp_mack;
            end else begin
              sh     <= {sh[6:0], 1'b0};
              sda_oe <= ~sh[6];
            end
          end
        end
        scp_mack: begin
          if (scl_rise) begin
            if (ara) begin
              mask_tgl <= ~mask_tgl;
              ara      <= 1'b0;
              state    <= scp_idle;
            end else begin
              host_ack <= ~sda;
              if (!sda) begin
                ptr      <= ptr + 8'h01;
                req_wr   <= 1'b0;
                req_addr <= ptr + 8'h01;
                req_tgl  <= ~req_tgl;
              end
            end
          end else if (scl_fall) begin
            if (host_ack) begin
              cnt    <= 4'h0;
              sh     <= rd_data_l;
              sda_oe <= ~rd_data_l[7];
              state  <= scp_txb;
            end else begin
              state <= scp_idle;
            end
          end
        end
        default: begin
          state  <= scp_idle;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************
  // System domain: synchronisers
  // ****************************************************
  logic [3:0] s_m;
  logic [3:0] s_s;
  logic [3:0] s_p;
  logic       req_ev;
  logic       mask_ev;

  // Pins plus toggles from the link; third stage only for edges
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_m <= 4'hC;
      s_s <= 4'hC;
      s_p <= 4'hC;
    end else begin
      s_m <= {scl_i, sda_i, req_tgl, mask_tgl};
      s_s <= s_m;
      s_p <= s_s;
    end
  end
  assign req_ev  = s_s[1] ^ s_p[1];
  assign mask_ev = s_s[0] ^ s_p[0];

  // ****************************************************
  // System domain: register access
  // ****************************************************
  logic rd_pend;

  // Request words are held still by the link until the next toggle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= 8'h00;
      reg_wdata <= 8'h00;
      rd_pend   <= 1'b0;
      rd_hold   <= 8'h00;
      rd_tgl    <= 1'b0;
    end else begin
      reg_wr  <= req_ev & req_wr;
      reg_rd  <= req_ev & ~req_wr;
      rd_pend <= reg_rd;
      if (req_ev) begin
        reg_addr  <= req_addr;
        reg_wdata <= req_data;
      end
      if (rd_pend) begin
        rd_hold <= reg_rdata;
        rd_tgl  <= ~rd_tgl;
      end
    end
  end

  // ****************************************************
  // System domain: alert pin and mask request
  // ****************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      alert_o   <= 1'b0;
      alert_oe  <= 1'b0;
      alert_ara <= 1'b0;
      mask_set  <= 1'b0;
    end else begin
      alert_o   <= 1'b0;
      alert_oe  <= alert_req & ~alert_mask;
      // Interrupt mode keeps the port deaf to the response address
      alert_ara <= alert_req & ~alert_mask & ~alert_irq_mode;
      mask_set  <= mask_ev;
    end
  end

  // ****************************************************
  // System domain: bus inactivity timeouts
  // ****************************************************
  logic [LW-1:0] lo_cnt;
  logic [HW-1:0] hi_cnt;

  // Counters saturate so each stuck period aborts only once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      lo_cnt    <= '0;
      hi_cnt    <= '0;
      abort_tgl <= 1'b0;
    end else begin
      if (!s_s[3]) begin
        if (lo_cnt != LW'(LOW_TO_CYC)) lo_cnt <= lo_cnt + 1'b1;
      end else begin
        lo_cnt <= '0;
      end
      if (s_s[3] && s_s[2]) begin
        if (hi_cnt != HW'(HIGH_TO_CYC)) hi_cnt <= hi_cnt + 1'b1;
      end else begin
        hi_cnt <= '0;
      end
      if ((!s_s[3] && lo_cnt == LW'(LOW_TO_CYC - 1) &&
           !timeout_disable_bit) ||
          (s_s[3] && s_s[2] && hi_cnt == HW'(HIGH_TO_CYC - 1))) begin
        abort_tgl <= ~abort_tgl;
      end
    end
  end

endmodule

//--- tb/scp_port_asserts.sv
// Concurrent checks on the ports of the two-wire client register port
module scp_port_asserts
  import scp_pkg::*;
#(
  parameter int LOW_TO_CYC = 200
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_oe,
  input wire logic       alert_oe,
  input wire logic       alert_req,
  input wire logic       alert_mask,
  input wire logic       alert_irq_mode,
  input wire logic       timeout_disable_bit,
  input wire logic       mask_set,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // Margin covers the pin synchronisers and the engine's own reaction
  localparam int LIM = LOW_TO_CYC + 40;
  logic       ps, pc, wv, rv, stp;
  logic [7:0] wa, ra;
  int         lc;
  wire        strt = pc & scl_i & ps & ~sda_i;
  wire        stop = pc & scl_i & ~ps & sda_i;
  // ********************
  // Bus event tracking
  // ********************
  always_ff @(posedge sys_clk) begin
    ps <= sda_i;
    pc <= scl_i;
  end
  // Clock-low duration, saturating
  always_ff @(posedge sys_clk)
    if (reset || scl_i) lc <= 0;
    else if (lc < LIM) lc <= lc + 1;
  // Last write and read address within one frame
  always_ff @(posedge sys_clk)
    if (reset || strt) wv <= 1'b0;
    else if (reg_wr) begin
      wv <= 1'b1;
      wa <= reg_addr;
    end
  always_ff @(posedge sys_clk)
    if (reset || strt) rv <= 1'b0;
    else if (reg_rd) begin
      rv <= 1'b1;
      ra <= reg_addr;
    end
  // Set by a stop, cleared by the next start
  always_ff @(posedge sys_clk)
    if (reset || strt) stp <= 1'b0;
    else if (stop) stp <= 1'b1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  chk_alert_follow: assert property (!$past(reset) |->
    alert_oe == $past(alert_req && !alert_mask))
    else $error("alert pin does not follow request and mask");
  chk_wr_single: assert property (reg_wr |-> s_pulse(reg_wr))
    else $error("write strobe longer than one cycle");
  chk_wr_incr: assert property (reg_wr && wv |-> reg_addr == wa + 8'h01)
    else $error("block write address not incremented");
  chk_rd_incr: assert property (reg_rd && rv |-> reg_addr == ra + 8'h01)
    else $error("block read address not incremented");
  chk_mask_cause: assert property (mask_set |->
    alert_oe && !alert_irq_mode ##1 !mask_set)
    else $error("mask set without a live bus alert");
  chk_low_timeout: assert property (lc == LIM && !timeout_disable_bit
    |-> !sda_oe) else $error("data line held after clock-low timeout");
  chk_ack_low_clk: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled low while clock high");
  chk_quiet_stop: assert property ((reg_wr || reg_rd) |-> !stp)
    else $error("register access after stop");
endmodule
bind scp_port scp_port_asserts #(.LOW_TO_CYC(LOW_TO_CYC)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .scl_i(scl_i), .sda_i(sda_i),
  .sda_oe(sda_oe), .alert_oe(alert_oe), .alert_req(alert_req),
  .alert_mask(alert_mask), .alert_irq_mode(alert_irq_mode),
  .timeout_disable_bit(timeout_disable_bit), .mask_set(mask_set),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr));

//--- tb/scp_host.sv
// Behavioural two-wire bus host driving the client port
module scp_host (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic     scl,
  output logic     sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************
  // Bus primitives
  // ********************
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One bit, 6.5 us period: well above the minimum rate
  task automatic bitx(input logic v, output logic r);
    w(5);
    sda = v;
    w(30);
    scl = 1'b1;
    w(30);
    r = sda_line;
    scl = 1'b0;
  endtask
  // Also used as repeated start
  task automatic start;
    w(10);
    sda = 1'b1;
    w(5);
    scl = 1'b1;
    w(30);
    sda = 1'b0;
    w(30);
    scl = 1'b0;
  endtask
  task automatic stop;
    w(10);
    sda = 1'b0;
    w(30);
    scl = 1'b1;
    w(30);
    sda = 1'b1;
    w(30);
  endtask
  // Both lines left high mid-frame for n cycles, then clock low again
  task automatic idle_hi(input int n);
    w(5);
    sda = 1'b1;
    w(30);
    scl = 1'b1;
    w(n);
    scl = 1'b0;
  endtask
  // Raw byte, MSB first, then ack slot; no count byte ever
  task automatic xfer(input logic [7:0] tx, input logic ack,
                      output logic [7:0] rx, output logic nak);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], b);
      rx[i] = b;
    end
    bitx(ack, nak);
  endtask
endmodule

//--- tb/smbus_client_register_port_tb.sv
// Self-checking bench for the two-wire client register port
`include "scp_defs.svh"
module smbus_client_register_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] WA  = {`SCP_CLIENT_ADDR, 1'b0};
  localparam logic [7:0] RA  = {`SCP_CLIENT_ADDR, 1'b1};
  localparam logic [7:0] ARA = {`SCP_ARA_ADDR, 1'b1};
  logic       sys_clk = 0, link_clk = 0, reset = 1, scl, hsda;
  logic       sda_o, sda_oe, alert_o, alert_oe, mask_set, reg_wr, reg_rd;
  logic       alert_req = 0, alert_mask = 0, irq = 0, tdis = 1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata = 8'h00, d, mem [256];
  logic       n;
  int         mismatches = 0, cmp_count = 0, wr_n = 0, mk_n = 0;
  wire        sda_i = hsda & (sda_oe ? sda_o : 1'b1);
  wire        alert_pin = alert_oe ? alert_o : 1'b1;
  always #50 sys_clk = ~sys_clk;
  always #32 link_clk = ~link_clk;
  scp_host h (.sys_clk(sys_clk), .sda_line(sda_i), .scl(scl), .sda(hsda));
  scp_port #(.LOW_TO_CYC(200), .HIGH_TO_CYC(50)) DUT (
    .sys_clk(sys_clk), .reset(reset), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
    .alert_oe(alert_oe), .alert_req(alert_req), .alert_mask(alert_mask),
    .alert_irq_mode(irq), .timeout_disable_bit(tdis),
    .mask_set(mask_set), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // ********************
  // Register set and mask bit
  // ********************
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(posedge sys_clk) begin
    if (reg_wr) mem[reg_addr] <= reg_wdata;
    if (reg_wr) wr_n <= wr_n + 1;
    if (reg_rd) reg_rdata <= mem[reg_addr];
    if (mask_set) alert_mask <= 1'b1;
    if (mask_set) mk_n <= mk_n + 1;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic put(input logic [7:0] b);
    h.xfer(b, 1'b1, d, n);
    chk({7'h00, n}, 8'h00);
  endtask
  task automatic get(input logic ack, input logic [7:0] e);
    h.xfer(8'hFF, ack, d, n);
    chk(d, e);
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_bwrite;
    h.start;
    put(WA);
    put(8'hFE);
    put(8'h11);
    put(8'h22);
    put(8'h33);
    h.stop;
    chk(mem[8'hFE], 8'h11);
    chk(mem[8'hFF], 8'h22);
    chk(mem[8'h00], 8'h33);
  endtask
  // Pointer-only write, then the same register read twice
  task automatic t_send_recv;
    int k = wr_n;
    h.start;
    put(WA);
    put(8'h40);
    h.stop;
    chk(8'(wr_n - k), 8'h00);
    repeat (2) begin
      h.start;
      put(RA);
      get(1'b1, 8'h40 ^ 8'h5A);
      h.stop;
    end
  endtask
  task automatic t_bread;
    h.start;
    put(WA);
    put(8'hFF);
    h.start;
    put(RA);
    get(1'b0, 8'h22);
    get(1'b0, 8'h33);
    get(1'b1, 8'h01 ^ 8'h5A);
    h.stop;
    h.start;
    h.xfer(WA ^ 8'h02, 1'b1, d, n);
    chk({7'h00, n}, 8'h01);
    h.stop;
  endtask
  task automatic t_alert;
    alert_req = 1'b1;
    irq = 1'b1;
    h.w(5);
    chk({7'h00, alert_pin}, 8'h00);
    h.start;
    h.xfer(ARA, 1'b1, d, n);
    chk({7'h00, n}, 8'h01);
    h.stop;
    irq = 1'b0;
    h.w(5);
    // Host holds data low while the port sends: lost bit, no mask
    h.start;
    put(ARA);
    h.xfer(8'h00, 1'b1, d, n);
    h.stop;
    chk(8'(mk_n), 8'h00);
    chk({7'h00, alert_pin}, 8'h00);
    h.start;
    put(ARA);
    get(1'b1, WA);
    h.stop;
    chk(8'(mk_n), 8'h01);
    chk({7'h00, alert_pin}, 8'h01);
  endtask
  // Both lines high mid-frame: the half-done frame must be dropped
  task automatic t_hi_reset;
    h.start;
    put(WA);
    h.idle_hi(80);
    h.xfer(8'h77, 1'b1, d, n);
    chk(d, 8'h77);
    chk({7'h00, n}, 8'h01);
    h.stop;
  endtask
  // Hold the clock low in the ack slot, timeout off then on
  task automatic t_timeout;
    logic b;
    for (int p = 0; p < 2; p++) begin
      h.start;
      for (int i = 7; i >= 0; i--) h.bitx(WA[i], b);
      h.w(300);
      chk({7'h00, sda_oe}, {7'h00, tdis});
      if (tdis) h.bitx(1'b1, b);
      h.stop;
      tdis = 1'b0;
    end
  endtask
  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    summarize;
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    h.w(10);
    t_bwrite;
    t_send_recv;
    t_bread;
    t_alert;
    t_hi_reset;
    t_timeout;
    summarize;
  end
endmodule
